// ==== logic/sdc_pkg.sv ====
// Contract
// R1 - mode low direct, mode high serial
// R2 - each drive input switches its own output
// R3 - overcurrent latches outputs off until standby/resupply
// R4 - overtemperature latches outputs off until standby/resupply
// R5 - motor supply good follows supply monitor
// R6 - logic enabled only when both supplies good
// R7 - fault flag low while a trip latched
// R8 - serial: 8-bit shift feeding 8-bit storage
// R9 - serial clock rise shifts data in
// R10 - serial clock fall changes nothing
// R11 - latch rise copies shift into storage
// R12 - latch fall changes nothing
// R13 - wipe low holds storage cleared
// R14 - stored enables applied only while apply high
// R15 - enable high on, low off/high impedance
// R16 - sleep low turns everything off; code only forces outputs off and clears trips, warning flag stays active
// R17 - undriven inputs default: apply high, others low
// R18 - host keeps serial clock low when idle
// R19 - thermal warning low, auto-release on cooling
// R20 - overcurrent ignores events under 2.0 us
// R21 - overtemperature needs 8.0 us before tripping
// R22 - host drives inputs no faster than 150 kHz
// R23 - storage bit to output mapping is configurable
// R24 - apply high enables outputs
package sdc_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int CHANNELS = 8;
	// mask times in nanoseconds, cycles rounded up
	localparam int OC_MASK_NS = 2000;
	localparam int OT_MASK_NS = 8000;
	localparam int OC_MASK_CYC = (OC_MASK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int OT_MASK_CYC = (OT_MASK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [7:0] STORE_RESET = 8'h00;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	// default bit-to-output order: bit0 first shifted -> a_pos, etc.
	localparam logic [23:0] DEFAULT_MAP = {3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0};
	localparam int SYNC_STAGES = 3;
endpackage : sdc_pkg

// ==== logic/sdc_sync.sv ====
`timescale 1ns/10ps
// three-stage input synchroniser; level moves when stages two and three agree
module sdc_sync import sdc_pkg::*; #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// pin side
	input wire logic i_pin,
	// filtered level
	output logic o_level
);
	logic s1;
	logic s2;
	logic s3;

	// first stage feeds only the second
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s1 <= RESET_VAL;
			s2 <= RESET_VAL;
			s3 <= RESET_VAL;
		end else begin
			s1 <= i_pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// accept a change only once stages two and three match
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_level <= RESET_VAL;
		end else if (s2 == s3) begin
			o_level <= s3;
		end
	end
endmodule : sdc_sync

// ==== logic/sdc_mask.sv ====
`timescale 1ns/10ps
// trip filter: sensor must stay high for MASK_CYC cycles to latch
module sdc_mask import sdc_pkg::*; #(
	parameter int MASK_CYC = OC_MASK_CYC
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// sensor and latch clear
	input wire logic i_sense,
	input wire logic i_clear,
	// latched trip
	output logic o_trip
);
	localparam int CW = $clog2(MASK_CYC + 1);
	localparam logic [CW-1:0] CNT_TOP = CW'(MASK_CYC);
	logic [CW-1:0] cnt;

	// short pulses restart the count, so switching noise never trips
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= '0;
		end else if (!i_sense || i_clear) begin
			cnt <= '0;
		end else if (cnt != CNT_TOP) begin
			cnt <= cnt + CW'(1);
		end
	end

	// a trip landing on a clear pulse still latches: safer to stay off
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_trip <= 1'b0;
		end else if (cnt == CNT_TOP) begin
			o_trip <= 1'b1;
		end else if (i_clear) begin
			o_trip <= 1'b0;
		end
	end
endmodule : sdc_mask

// ==== logic/sdc_ctrl.sv ====
`timescale 1ns/10ps
module sdc_ctrl import sdc_pkg::*; #(
	parameter int OC_CYC = OC_MASK_CYC,
	parameter int OT_CYC = OT_MASK_CYC,
	parameter logic [23:0] BIT_MAP = DEFAULT_MAP
) (
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// mode and supplies
	input wire logic i_shifted_drive_mode,
	input wire logic i_motor_supply_good,
	input wire logic i_logic_supply_good,
	// direct drive inputs, order a_pos..d_neg
	input wire logic i_drive_a_pos_in,
	input wire logic i_drive_a_neg_in,
	input wire logic i_drive_b_pos_in,
	input wire logic i_drive_b_neg_in,
	input wire logic i_drive_c_pos_in,
	input wire logic i_drive_c_neg_in,
	input wire logic i_drive_d_pos_in,
	input wire logic i_drive_d_neg_in,
	// serial pins, shared with drive pins on the package
	input wire logic i_ser_clk,
	input wire logic i_ser_data,
	input wire logic i_storage_wipe_n,
	input wire logic i_ser_latch,
	input wire logic i_apply,
	input wire logic i_sleep_n,
	// analog sensors
	input wire logic i_overcurrent_sense,
	input wire logic i_overtemp_sense,
	input wire logic i_warn_sense,
	// output switches, order a_pos..d_neg
	output logic [7:0] o_switch_on,
	// status
	output logic o_motor_supply_good,
	output logic o_logic_enable,
	output logic o_overcurrent_trip,
	output logic o_overtemp_trip,
	// open-drain fault flag
	output logic o_fault_n_out,
	output logic o_fault_n_oe,
	// open-drain thermal warning
	output logic o_thermal_warn_n_out,
	output logic o_thermal_warn_n_oe
);
	////////////////////////////////////////////////////////////////////////////
	// synchronised pins
	logic [7:0] drive_raw;
	logic [7:0] drive;
	logic [13:0] misc_raw;
	logic [13:0] misc;
	// undriven pins default: apply high, rest low
	localparam logic [13:0] MISC_RST = 14'h0010; // R17
	assign drive_raw = {i_drive_d_neg_in, i_drive_d_pos_in, i_drive_c_neg_in, i_drive_c_pos_in,
		i_drive_b_neg_in, i_drive_b_pos_in, i_drive_a_neg_in, i_drive_a_pos_in};
	assign misc_raw = {i_warn_sense, i_overtemp_sense, i_overcurrent_sense,
		i_logic_supply_good, i_motor_supply_good, i_shifted_drive_mode, i_sleep_n,
		i_ser_latch, i_storage_wipe_n, i_apply, i_ser_data, i_ser_clk, 2'h0};

	genvar g;
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_drv
			sdc_sync #(.RESET_VAL(1'b0)) u_sync (
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_pin(drive_raw[g]),
				.o_level(drive[g])
			);
		end
		for (g = 2; g < 14; g++) begin : g_misc
			sdc_sync #(.RESET_VAL(MISC_RST[g])) u_sync (
				.i_ref_clk(i_ref_clk),
				.i_rst(i_rst),
				.i_pin(misc_raw[g]),
				.o_level(misc[g])
			);
		end
	endgenerate
	assign misc[1:0] = 2'h0;

	logic s_clk;
	logic s_data;
	logic s_apply;
	logic s_wipe_n;
	logic s_latch;
	logic s_sleep_n;
	logic s_mode;
	logic s_vm_good;
	logic s_vcc_good;
	logic s_oc;
	logic s_ot;
	logic s_warn;
	assign s_clk = misc[2];
	assign s_data = misc[3];
	assign s_apply = misc[4];
	assign s_wipe_n = misc[5];
	assign s_latch = misc[6];
	assign s_sleep_n = misc[7];
	assign s_mode = misc[8];
	assign s_vm_good = misc[9];
	assign s_vcc_good = misc[10];
	assign s_oc = misc[11];
	assign s_ot = misc[12];
	assign s_warn = misc[13];

	////////////////////////////////////////////////////////////////////////////
	// power-on reset and supply status
	logic logic_on;
	logic vm_prev;
	logic vm_rise;
	assign logic_on = s_vm_good && s_vcc_good; // R6
	assign vm_rise = s_vm_good && !vm_prev;

	// motor supply status follows the monitor
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			vm_prev <= 1'b0;
			o_motor_supply_good <= 1'b0;
			o_logic_enable <= 1'b0;
		end else begin
			vm_prev <= s_vm_good;
			o_motor_supply_good <= s_vm_good; // R5
			o_logic_enable <= logic_on; // R6
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fault latches; standby or motor resupply clears them
	logic trip_clear;
	logic oc_trip;
	logic ot_trip;
	assign trip_clear = !s_sleep_n || vm_rise || !logic_on; // R3 R4

	sdc_mask #(.MASK_CYC(OC_CYC)) u_oc ( // R20
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_sense(s_oc),
		.i_clear(trip_clear),
		.o_trip(oc_trip)
	);

	sdc_mask #(.MASK_CYC(OT_CYC)) u_ot ( // R21
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_sense(s_ot),
		.i_clear(trip_clear),
		.o_trip(ot_trip)
	);

	// fault flag pulls low while either latch holds
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_overcurrent_trip <= 1'b0;
			o_overtemp_trip <= 1'b0;
			o_fault_n_out <= 1'b0;
			o_fault_n_oe <= 1'b0;
		end else begin
			o_overcurrent_trip <= oc_trip;
			o_overtemp_trip <= ot_trip;
			o_fault_n_oe <= oc_trip || ot_trip; // R7
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial shift and storage registers
	logic [7:0] shift;
	logic [7:0] store;
	logic clk_prev;
	logic latch_prev;
	logic clk_rise;
	logic latch_rise;
	assign clk_rise = s_clk && !clk_prev;
	assign latch_rise = s_latch && !latch_prev;

	// edge detectors run off the filtered level, never the first stage
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			clk_prev <= 1'b0;
			latch_prev <= 1'b0;
		end else begin
			clk_prev <= s_clk;
			latch_prev <= s_latch;
		end
	end

	// bit0 is the first stage; only rising edges move data
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			shift <= SHIFT_RESET;
		end else if (s_mode && s_wipe_n && clk_rise && logic_on) begin
			shift <= {shift[6:0], s_data}; // R8 R9 R10
		end
	end

	// wipe dominates any latch strobe
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			store <= STORE_RESET;
		end else if (!s_wipe_n || !logic_on) begin
			store <= STORE_RESET; // R13
		end else if (s_mode && latch_rise) begin
			store <= shift; // R11 R12
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output selection
	logic [7:0] mapped;
	logic [7:0] next_switch;
	// last shifted bit sits in store[0]; reverse so first shifted is a_pos
	generate
		for (g = 0; g < CHANNELS; g++) begin : g_map
			assign mapped[g] = store[3'h7 - BIT_MAP[g*3 +: 3]]; // R23
		end
	endgenerate

	always_comb begin
		if (!logic_on || !s_sleep_n || oc_trip || ot_trip) begin
			next_switch = 8'h00; // R3 R4 R6 R16
		end else if (!s_mode) begin
			next_switch = drive; // R1 R2
		end else if (s_apply) begin
			next_switch = mapped; // R14 R15 R24
		end else begin
			next_switch = 8'h00;
		end
	end

	// registered drive to the power stage
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_switch_on <= 8'h00;
		end else begin
			o_switch_on <= next_switch;
		end
	end

	// warning only meaningful in serial mode; sensor has its own hysteresis
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_thermal_warn_n_out <= 1'b0;
			o_thermal_warn_n_oe <= 1'b0;
		end else begin
			o_thermal_warn_n_oe <= s_mode && s_warn && logic_on; // R19
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	chk_fault_flag: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
		(oc_trip || ot_trip) |=> o_fault_n_oe)
		else $error("fault flag not pulled low");
	chk_trip_off: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
		oc_trip |=> o_switch_on == 8'h00)
		else $error("outputs on during overcurrent");
	chk_temp_off: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
		ot_trip |=> o_switch_on == 8'h00)
		else $error("outputs on during overtemperature");
	chk_sleep_off: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R16
		!s_sleep_n |=> o_switch_on == 8'h00 ##1 !oc_trip)
		else $error("outputs or trip active in standby");
	chk_wipe_store: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R13
		!s_wipe_n |=> store == STORE_RESET)
		else $error("storage not cleared");
	chk_latch_copy: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R11
		(s_mode && latch_rise && s_wipe_n && logic_on) |=> store == $past(shift))
		else $error("latch did not copy shift");
	chk_shift_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R10
		!clk_rise |=> $stable(shift))
		else $error("shift moved without rising clock");
	chk_direct_drive: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R2
		(!s_mode && logic_on && s_sleep_n && !oc_trip && !ot_trip) |=> o_switch_on == $past(drive))
		else $error("direct drive mismatch");
	chk_apply_gate: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R14
		(s_mode && !s_apply) |=> o_switch_on == 8'h00)
		else $error("stored data applied while apply low");
	chk_oc_mask: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R20
		(!oc_trip && !s_oc && !$past(s_oc)) |=> !oc_trip)
		else $error("overcurrent tripped without sense");
	chk_ot_mask: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R21
		(!ot_trip && !s_ot && !$past(s_ot)) |=> !ot_trip)
		else $error("overtemperature tripped without sense");
	chk_trip_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
		(oc_trip && !trip_clear) |=> oc_trip)
		else $error("overcurrent latch released early");
	chk_temp_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R4
		(ot_trip && !trip_clear) |=> ot_trip)
		else $error("overtemperature latch released early");
	chk_fault_release: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R7
		!(oc_trip || ot_trip) |=> !o_fault_n_oe)
		else $error("fault flag held without a trip");
	chk_supply_high: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
		s_vm_good |=> o_motor_supply_good)
		else $error("motor supply status low while good");
	chk_supply_low: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R5
		!s_vm_good |=> !o_motor_supply_good)
		else $error("motor supply status high while bad");
	chk_poweron_off: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R6
		!logic_on |=> (o_switch_on == 8'h00) && !o_logic_enable)
		else $error("logic active without both supplies");
	chk_shift_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
		!s_mode |=> $stable(shift))
		else $error("shift moved in direct mode");
	chk_store_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R1
		(!s_mode && s_wipe_n && logic_on) |=> $stable(store))
		else $error("storage moved in direct mode");
	chk_shift_wipe: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
		!s_wipe_n |=> $stable(shift))
		else $error("shift moved while wipe low");
	chk_shift_in: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R9
		(s_mode && s_wipe_n && clk_rise && logic_on) |=> shift[0] == $past(s_data))
		else $error("first stage did not take serial data");
	chk_store_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R12
		(!latch_rise && s_wipe_n && logic_on) |=> $stable(store))
		else $error("storage moved without latch rise");
	chk_warn_mode: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
		!s_mode |=> !o_thermal_warn_n_oe)
		else $error("thermal warning active in direct mode");
	chk_warn_low: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
		(s_mode && s_warn && logic_on) |=> o_thermal_warn_n_oe)
		else $error("thermal warning not pulled low");
	chk_warn_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R19
		!s_warn |=> !o_thermal_warn_n_oe)
		else $error("thermal warning not released");

	// run length of the filtered sense, kept apart from the mask counter
	logic [15:0] oc_run;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			oc_run <= '0;
		end else if (!s_oc || trip_clear) begin
			oc_run <= '0;
		end else if (oc_run != 16'hffff) begin
			oc_run <= oc_run + 16'h0001;
		end
	end
	chk_oc_early: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R20
		(!oc_trip && oc_run < OC_CYC) |=> !oc_trip)
		else $error("overcurrent tripped inside mask time");
	chk_oc_trips: assert property (@(posedge i_ref_clk) disable iff (i_rst) // R3
		(oc_run == OC_CYC) |=> oc_trip)
		else $error("overcurrent did not trip after mask time");
endmodule : sdc_ctrl

// ==== verification/sdc_host.sv ====
`timescale 1ns/10ps
// host controller on the serial pins; everything moves on the falling clock edge
module sdc_host #(
	parameter int HALF = 175
) (
	// clock
	input wire logic i_ref_clk,
	// serial pins toward the block
	output logic o_ser_clk,
	output logic o_ser_data,
	output logic o_ser_latch
);
	initial begin
		o_ser_clk = 1'b0;
		o_ser_data = 1'b0;
		o_ser_latch = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// half period of 3.5 us keeps the link below 150 kHz
	task automatic send(input logic [7:0] b, input logic do_latch);
		for (int i = 0; i < 8; i++) begin
			@(negedge i_ref_clk);
			o_ser_data = b[i];
			repeat (HALF) @(negedge i_ref_clk);
			o_ser_clk = 1'b1;
			repeat (HALF) @(negedge i_ref_clk);
			o_ser_clk = 1'b0;
		end
		// data is not held after the frame, so show the inverse
		o_ser_data = ~b[7];
		if (do_latch) begin
			repeat (HALF) @(negedge i_ref_clk);
			o_ser_latch = 1'b1;
			repeat (HALF) @(negedge i_ref_clk);
			o_ser_latch = 1'b0;
		end
		repeat (HALF) @(negedge i_ref_clk);
	endtask : send
endmodule : sdc_host

// ==== verification/sdc_ctrl_tb_top.sv ====
`timescale 1ns/10ps
module sdc_ctrl_tb_top;
	import sdc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic mode = 1'b0;
	logic msg = 1'b1;
	logic lsg = 1'b1;
	logic [7:0] drv = 8'h00;
	logic wipe_n = 1'b1;
	logic apply = 1'b1;
	logic sleep_n = 1'b1;
	logic oc = 1'b0;
	logic ot = 1'b0;
	logic warn = 1'b0;
	logic sck;
	logic sdat;
	logic slat;
	logic [7:0] sw;
	logic [7:0] st;
	logic f_out, f_oe, w_out, w_oe, mgood, len, oct, ott;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	assign st = {f_out, w_out, w_oe, len, mgood, f_oe, oct, ott};
	always #10 clk = ~clk;
	////////////////////////////////////////////////////////////////
	// short mask counts keep the fault scenarios brief
	sdc_host u_host (.i_ref_clk(clk), .o_ser_clk(sck), .o_ser_data(sdat), .o_ser_latch(slat));
	sdc_ctrl #(.OC_CYC(5), .OT_CYC(10)) u_dut (
		.i_ref_clk(clk), .i_rst(rst), .i_shifted_drive_mode(mode),
		.i_motor_supply_good(msg), .i_logic_supply_good(lsg),
		.i_drive_a_pos_in(drv[0]), .i_drive_a_neg_in(drv[1]),
		.i_drive_b_pos_in(drv[2]), .i_drive_b_neg_in(drv[3]),
		.i_drive_c_pos_in(drv[4]), .i_drive_c_neg_in(drv[5]),
		.i_drive_d_pos_in(drv[6]), .i_drive_d_neg_in(drv[7]),
		.i_ser_clk(sck), .i_ser_data(sdat), .i_storage_wipe_n(wipe_n), .i_ser_latch(slat),
		.i_apply(apply), .i_sleep_n(sleep_n), .i_overcurrent_sense(oc),
		.i_overtemp_sense(ot), .i_warn_sense(warn), .o_switch_on(sw),
		.o_motor_supply_good(mgood), .o_logic_enable(len), .o_overcurrent_trip(oct),
		.o_overtemp_trip(ott), .o_fault_n_out(f_out), .o_fault_n_oe(f_oe),
		.o_thermal_warn_n_out(w_out), .o_thermal_warn_n_oe(w_oe));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic settle();
		repeat (8) @(negedge clk);
	endtask : settle
	task automatic pulse(ref logic s, input int n);
		s = 1'b1;
		repeat (n) @(negedge clk);
		s = 1'b0;
		settle();
	endtask : pulse
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	task automatic t_direct();
		check(st, 8'h18);
		for (int i = 0; i < 8; i++) begin
			drv = 8'h01 << i;
			settle();
			check(sw, 8'h01 << i);
		end
		drv = 8'hff;
		mode = 1'b1;
		settle();
		check(sw, 8'h00);
	endtask : t_direct
	task automatic t_serial();
		u_host.send(8'h2d, 1'b1);
		settle();
		check(sw, 8'h2d);
		apply = 1'b0;
		settle();
		check(sw, 8'h00);
		apply = 1'b1;
		settle();
		check(sw, 8'h2d);
		u_host.send(8'hc3, 1'b0);
		check(sw, 8'h2d);
		u_host.send(8'h5a, 1'b1);
		check(sw, 8'h5a);
	endtask : t_serial
	task automatic t_wipe();
		wipe_n = 1'b0;
		settle();
		check(sw, 8'h00);
		u_host.send(8'hff, 1'b1);
		check(sw, 8'h00);
		wipe_n = 1'b1;
		settle();
		check(sw, 8'h00);
	endtask : t_wipe
	task automatic t_overcurrent();
		u_host.send(8'h55, 1'b1);
		pulse(oc, 3);
		check(st, 8'h18);
		pulse(oc, 20);
		check(sw, 8'h00);
		check(st, 8'h1e);
		sleep_n = 1'b0;
		settle();
		check(sw, 8'h00);
		sleep_n = 1'b1;
		settle();
		check(st, 8'h18);
		check(sw, 8'h55);
		sleep_n = 1'b0;
		settle();
		check(sw, 8'h00);
		sleep_n = 1'b1;
		settle();
		check(sw, 8'h55);
	endtask : t_overcurrent
	task automatic t_overtemp();
		u_host.send(8'haa, 1'b1);
		check(sw, 8'haa);
		pulse(ot, 5);
		check(st, 8'h18);
		pulse(ot, 30);
		check(sw, 8'h00);
		check(st, 8'h1d);
		msg = 1'b0;
		settle();
		check(st, 8'h00);
		msg = 1'b1;
		settle();
		check(st, 8'h18);
		lsg = 1'b0;
		settle();
		check(st, 8'h08);
		lsg = 1'b1;
		settle();
	endtask : t_overtemp
	task automatic t_warn();
		warn = 1'b1;
		settle();
		check(st, 8'h38);
		warn = 1'b0;
		settle();
		check(st, 8'h18);
		mode = 1'b0;
		warn = 1'b1;
		settle();
		check(st, 8'h18);
	endtask : t_warn
	////////////////////////////////////////////////////////////////
	// hang guard sized well above the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		settle();
		t_direct();
		t_serial();
		t_wipe();
		t_overcurrent();
		t_overtemp();
		t_warn();
		tally_and_finish();
	end
endmodule : sdc_ctrl_tb_top
